//--- logic/tmr_timers.sv
// Timers zero, one and two with an AHB-Lite register slave
`timescale 1ns/1ns
module tmr_timers #(
  parameter int PRESCALE_01 = 12
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        count_input_zero,
  input  wire logic        count_input_one,
  input  wire logic        gate_pin_zero,
  input  wire logic        gate_pin_one,
  input  wire logic [2:0]  capture_pin,
  output logic             baud_tick,
  output logic             timer_zero_overflow,
  output logic             timer_one_overflow,
  output logic             t2_flag
);
  // Elaboration check on the timer zero/one prescale
  if (PRESCALE_01 < 2 || PRESCALE_01 > 255) begin : g_chk
    $error("PRESCALE_01 out of range");
  end

  // One step of a timer-zero/one counter for modes 0..3; returns {ovf, high, low}
  function automatic logic [16:0] step_count(input logic [1:0] md, input logic [7:0] hi,
                                             input logic [7:0] lo);
    logic [16:0] r;
    logic [13:0] c13;
    r = {1'b0, hi, lo};
    c13 = 14'h0000;
    case (md)
      2'd0: begin
        c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        r = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
      end
      2'd1: r = {1'b0, hi, lo} + 17'h00001;
      2'd2: r = (lo == 8'hff) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
      default: r = {(lo == 8'hff), hi, lo + 8'h01};
    endcase
    return r;
  endfunction

  // Prescaler mask for a timer two divide code
  function automatic logic [8:0] div_mask(input logic [2:0] code);
    return 9'((tmr_pkg::T2_MIN_DIV << code) - 1);
  endfunction

  localparam int PW = 8;
  localparam int NSYNC = 7;

  logic [7:0]  tctl_ff, tmode_ff, t2ctl_ff, timer2_mode_ff;
  logic [7:0]  timer_zero_low_byte_ff, timer_zero_high_byte_ff;
  logic [7:0]  timer_one_low_ff, timer_one_high_ff;
  logic [15:0] t2_count_ff, reload_compare_ff;
  logic [15:0] capture_ff [3];
  logic [PW-1:0] pre01_ff;
  logic [8:0]  pre2_ff;
  logic [NSYNC-1:0] s1_ff, s2_ff, s3_ff, clean_ff, clean_d_ff;
  tmr_pkg::tmr_bus_state_t bus_st_ff;
  logic        wr_pend_ff;
  logic [7:0]  wr_idx_ff, rd_idx_ff;
  logic [31:0] hrdata_ff;
  logic        hreadyout_ff, baud_tick_ff;

  // Input synchroniser: three stages, a change counts once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      clean_ff <= '0;
      clean_d_ff <= '0;
    end else begin
      s1_ff <= {capture_pin, gate_pin_one, gate_pin_zero, count_input_one, count_input_zero};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      clean_ff <= (s2_ff & s3_ff) | (clean_ff & (s2_ff ^ s3_ff));
      clean_d_ff <= clean_ff;
    end
  end

  logic [1:0] ext_fall;
  logic [1:0] gate_lvl;
  logic [2:0] cap_evt;
  assign ext_fall = clean_d_ff[1:0] & ~clean_ff[1:0];
  assign gate_lvl = clean_ff[3:2];
  assign cap_evt  = clean_ff[6:4] & ~clean_d_ff[6:4];

  // Bus slave: writes with no wait, reads with one wait state
  logic        addr_ok;
  logic        wr_en;
  logic [7:0]  wr_data;
  assign addr_ok = hsel && htrans[1] && hready;
  assign wr_en   = wr_pend_ff;
  assign wr_data = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_st_ff <= tmr_pkg::TMR_BS_IDLE;
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= 8'h00;
      rd_idx_ff <= 8'h00;
      hreadyout_ff <= 1'b1;
    end else begin
      wr_pend_ff <= addr_ok && hwrite && bus_st_ff == tmr_pkg::TMR_BS_IDLE;
      case (bus_st_ff)
        tmr_pkg::TMR_BS_IDLE: begin
          if (addr_ok) begin
            wr_idx_ff <= haddr[9:2];
            rd_idx_ff <= haddr[9:2];
            if (!hwrite) begin
              bus_st_ff <= tmr_pkg::TMR_BS_RDWAIT;
              hreadyout_ff <= 1'b0;
            end
          end
        end
        tmr_pkg::TMR_BS_RDWAIT: begin
          bus_st_ff <= tmr_pkg::TMR_BS_IDLE;
          hreadyout_ff <= 1'b1;
        end
        default: begin
          bus_st_ff <= tmr_pkg::TMR_BS_IDLE;
          hreadyout_ff <= 1'b1;
        end
      endcase
    end
  end

  // Read mux, sampled in the wait cycle; unmapped reads return zero
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    case (rd_idx_ff)
      tmr_pkg::IDX_TCTL:  rd_val = tctl_ff;
      tmr_pkg::IDX_TMODE: rd_val = tmode_ff;
      tmr_pkg::IDX_T0L:   rd_val = timer_zero_low_byte_ff;
      tmr_pkg::IDX_T0H:   rd_val = timer_zero_high_byte_ff;
      tmr_pkg::IDX_T1L:   rd_val = timer_one_low_ff;
      tmr_pkg::IDX_T1H:   rd_val = timer_one_high_ff;
      tmr_pkg::IDX_T2CTL: rd_val = t2ctl_ff & 8'h85;
      tmr_pkg::IDX_TIMER2_MODE: rd_val = timer2_mode_ff;
      tmr_pkg::IDX_RCL:   rd_val = reload_compare_ff[7:0];
      tmr_pkg::IDX_RCH:   rd_val = reload_compare_ff[15:8];
      tmr_pkg::IDX_T2L:   rd_val = t2_count_ff[7:0];
      tmr_pkg::IDX_T2H:   rd_val = t2_count_ff[15:8];
      8'he0: rd_val = capture_ff[0][7:0];
      8'he1: rd_val = capture_ff[0][15:8];
      8'he2: rd_val = capture_ff[1][7:0];
      8'he3: rd_val = capture_ff[1][15:8];
      8'he4: rd_val = capture_ff[2][7:0];
      8'he5: rd_val = capture_ff[2][15:8];
      default: rd_val = 8'h00;
    endcase
  end

  // Read data register and fixed OKAY response
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (bus_st_ff == tmr_pkg::TMR_BS_RDWAIT) begin
      hrdata_ff <= {24'h000000, rd_val};
    end
  end

  // Decoded controls for timers zero and one
  logic [1:0] mode0, mode1;
  logic       t0_m3, run0, run1, en0, en1, src0, src1;
  logic       pre01_tick;
  assign mode0 = tmode_ff[1:0];
  assign mode1 = tmode_ff[5:4];
  assign t0_m3 = mode0 == 2'd3;
  assign run0  = tctl_ff[tmr_pkg::TC_T0RUN];
  assign run1  = t0_m3 ? 1'b1 : tctl_ff[tmr_pkg::TC_T1RUN];
  assign en0   = run0 && (!tmode_ff[tmr_pkg::TM_QUAL] || gate_lvl[0]);
  assign en1   = run1 && (!tmode_ff[4 + tmr_pkg::TM_QUAL] || gate_lvl[1]);
  assign pre01_tick = pre01_ff == PW'(PRESCALE_01 - 1);
  assign src0  = tmode_ff[tmr_pkg::TM_CSEL] ? ext_fall[0] : pre01_tick;
  assign src1  = tmode_ff[4 + tmr_pkg::TM_CSEL] ? ext_fall[1] : pre01_tick;

  // Shared prescaler for timers zero and one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre01_ff <= '0;
    end else begin
      pre01_ff <= pre01_tick ? '0 : pre01_ff + PW'(1);
    end
  end

  logic [16:0] nxt_t0, nxt_t1;
  logic        inc0, inc1, inc0h, ovf0, ovf1, ovf0h;
  assign inc0  = src0 && en0;
  assign inc1  = src1 && en1 && mode1 != 2'd3;
  assign inc0h = t0_m3 && pre01_tick && tctl_ff[tmr_pkg::TC_T1RUN];
  assign nxt_t0 = step_count(mode0, timer_zero_high_byte_ff, timer_zero_low_byte_ff);
  assign nxt_t1 = step_count(mode1, timer_one_high_ff, timer_one_low_ff);
  assign ovf0  = inc0 && nxt_t0[16];
  assign ovf1  = inc1 && nxt_t1[16];
  assign ovf0h = inc0h && timer_zero_high_byte_ff == 8'hff;

  // Timer zero count bytes; a bus write wins over counting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_zero_low_byte_ff  <= tmr_pkg::RST_REG;
      timer_zero_high_byte_ff <= tmr_pkg::RST_REG;
    end else begin
      if (wr_en && wr_idx_ff == tmr_pkg::IDX_T0L) begin
        timer_zero_low_byte_ff <= wr_data;
      end else if (inc0) begin
        timer_zero_low_byte_ff <= nxt_t0[7:0];
      end
      if (wr_en && wr_idx_ff == tmr_pkg::IDX_T0H) begin
        timer_zero_high_byte_ff <= wr_data;
      end else if (inc0h) begin
        timer_zero_high_byte_ff <= timer_zero_high_byte_ff + 8'h01;
      end else if (inc0 && !t0_m3) begin
        timer_zero_high_byte_ff <= nxt_t0[15:8];
      end
    end
  end

  // Timer one count bytes; held still in its own mode 3
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_one_low_ff  <= tmr_pkg::RST_REG;
      timer_one_high_ff <= tmr_pkg::RST_REG;
    end else begin
      if (wr_en && wr_idx_ff == tmr_pkg::IDX_T1L) begin
        timer_one_low_ff <= wr_data;
      end else if (inc1) begin
        timer_one_low_ff <= nxt_t1[7:0];
      end
      if (wr_en && wr_idx_ff == tmr_pkg::IDX_T1H) begin
        timer_one_high_ff <= wr_data;
      end else if (inc1) begin
        timer_one_high_ff <= nxt_t1[15:8];
      end
    end
  end

  // Timer control and mode registers; hardware flag set wins over software clear
  logic t1_flag_set;
  assign t1_flag_set = t0_m3 ? ovf0h : ovf1;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tctl_ff  <= tmr_pkg::RST_REG;
      tmode_ff <= tmr_pkg::RST_REG;
    end else begin
      if (wr_en && wr_idx_ff == tmr_pkg::IDX_TCTL) begin
        tctl_ff <= wr_data;
      end
      if (wr_en && wr_idx_ff == tmr_pkg::IDX_TMODE) begin
        tmode_ff <= wr_data;
      end
      if (ovf0) begin
        tctl_ff[tmr_pkg::TC_T0FLAG] <= 1'b1;
      end
      if (t1_flag_set) begin
        tctl_ff[tmr_pkg::TC_T1FLAG] <= 1'b1;
      end
    end
  end

  // Serial baud tick from timer one overflow only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_tick_ff <= 1'b0;
    end else begin
      baud_tick_ff <= ovf1;
    end
  end

  // Timer two decoded controls
  logic       t2_run, csel, ld_en, cap_ld_mode, t2_tick, ovf2, match2, cap_any, reload_now;
  logic [1:0] trig;
  logic [15:0] cnt_inc;
  assign t2_run  = t2ctl_ff[tmr_pkg::T2C_RUN];
  assign csel    = t2ctl_ff[tmr_pkg::T2C_CSEL];
  assign ld_en   = timer2_mode_ff[tmr_pkg::T2M_RELOAD_ENABLE];
  assign trig    = timer2_mode_ff[tmr_pkg::T2M_TRIG +: 2];
  assign cap_ld_mode = !csel;
  assign t2_tick = t2_run && (pre2_ff & div_mask(timer2_mode_ff[tmr_pkg::T2M_DIV +: 3]))
                   == div_mask(timer2_mode_ff[tmr_pkg::T2M_DIV +: 3]);
  assign cnt_inc = t2_count_ff + 16'h0001;
  assign ovf2    = t2_tick && t2_count_ff == 16'hffff;
  assign match2  = t2_tick && csel && cnt_inc == reload_compare_ff;
  assign cap_any = cap_ld_mode && |cap_evt;
  // Reload trigger: overflow or one capture channel
  assign reload_now = cap_ld_mode && ld_en &&
                      (trig == 2'd0 ? ovf2 : cap_evt[trig - 2'd1]);

  // Timer two prescaler runs only while enabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre2_ff <= 9'h000;
    end else if (t2_run) begin
      pre2_ff <= pre2_ff + 9'h001;
    end
  end

  // Timer two counter: write, reload, auto-clear, then count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t2_count_ff <= tmr_pkg::RST_WORD;
    end else if (wr_en && wr_idx_ff == tmr_pkg::IDX_T2L) begin
      t2_count_ff[7:0] <= wr_data;
    end else if (wr_en && wr_idx_ff == tmr_pkg::IDX_T2H) begin
      t2_count_ff[15:8] <= wr_data;
    end else if (reload_now) begin
      t2_count_ff <= reload_compare_ff;
    end else if (cap_any && timer2_mode_ff[tmr_pkg::T2M_CAPC]) begin
      t2_count_ff <= 16'h0000;
    end else if (match2 && timer2_mode_ff[tmr_pkg::T2M_CMPC]) begin
      t2_count_ff <= 16'h0000;
    end else if (t2_tick) begin
      t2_count_ff <= cnt_inc;
    end
  end

  // Capture registers, one pair per channel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 3; i++) begin
        capture_ff[i] <= tmr_pkg::RST_WORD;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (cap_ld_mode && cap_evt[i]) begin
          capture_ff[i] <= t2_count_ff;
        end
      end
    end
  end

  // Timer two control, mode and reload registers; flag set beats clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t2ctl_ff <= tmr_pkg::RST_REG;
      timer2_mode_ff <= tmr_pkg::RST_REG;
      reload_compare_ff <= tmr_pkg::RST_WORD;
    end else begin
      if (wr_en && wr_idx_ff == tmr_pkg::IDX_T2CTL) begin
        t2ctl_ff <= wr_data & 8'h85;
      end
      if (wr_en && wr_idx_ff == tmr_pkg::IDX_TIMER2_MODE) begin
        timer2_mode_ff <= wr_data;
      end
      if (wr_en && wr_idx_ff == tmr_pkg::IDX_RCL) begin
        reload_compare_ff[7:0] <= wr_data;
      end
      if (wr_en && wr_idx_ff == tmr_pkg::IDX_RCH) begin
        reload_compare_ff[15:8] <= wr_data;
      end
      if (ovf2 || match2) begin
        t2ctl_ff[tmr_pkg::T2C_FLAG] <= 1'b1;
      end
    end
  end

  assign hrdata    = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp     = 1'b0;
  assign baud_tick = baud_tick_ff;
  assign timer_zero_overflow = tctl_ff[tmr_pkg::TC_T0FLAG];
  assign timer_one_overflow  = tctl_ff[tmr_pkg::TC_T1FLAG];
  assign t2_flag   = t2ctl_ff[tmr_pkg::T2C_FLAG];

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_t2_hold;
    !t2_run && !wr_en && !reload_now && !cap_any |=> $stable(t2_count_ff);
  endproperty
  a_t2_hold: assert property (p_t2_hold) else $error("timer two moved while halted");

  property p_t2_flag_sticky;
    t2_flag && !(wr_en && wr_idx_ff == tmr_pkg::IDX_T2CTL) |=> t2_flag;
  endproperty
  a_t2_flag_sticky: assert property (p_t2_flag_sticky) else $error("t2 flag cleared");

  property p_t1_freeze;
    mode1 == 2'd3 && !wr_en |=> $stable({timer_one_high_ff, timer_one_low_ff});
  endproperty
  a_t1_freeze: assert property (p_t1_freeze) else $error("timer one not frozen");

  property p_mode2_reload;
    mode0 == 2'd2 && ovf0 && !wr_en
      |=> timer_zero_low_byte_ff == $past(timer_zero_high_byte_ff) && timer_zero_overflow;
  endproperty
  a_mode2_reload: assert property (p_mode2_reload) else $error("mode 2 reload wrong");

  property p_mode1_wrap;
    mode0 == 2'd1 && inc0 && timer_zero_high_byte_ff == 8'hff &&
      timer_zero_low_byte_ff == 8'hff && !wr_en
      |=> {timer_zero_high_byte_ff, timer_zero_low_byte_ff} == 16'h0000 && timer_zero_overflow;
  endproperty
  a_mode1_wrap: assert property (p_mode1_wrap) else $error("mode 1 wrap wrong");

  property p_baud_t1;
    baud_tick == $past(ovf1);
  endproperty
  a_baud_t1: assert property (p_baud_t1) else $error("baud tick not from timer one");

  property p_t2_div;
    t2_tick |=> !t2_tick [*3];
  endproperty
  a_t2_div: assert property (p_t2_div) else $error("timer two ticks too fast");

  property p_cmp_clear;
    match2 && timer2_mode_ff[tmr_pkg::T2M_CMPC] && !wr_en && !cap_any |=> t2_count_ff == 16'h0000;
  endproperty
  a_cmp_clear: assert property (p_cmp_clear) else $error("compare clear missed");

  property p_cap_store;
    cap_ld_mode && cap_evt[0] |=> capture_ff[0] == $past(t2_count_ff);
  endproperty
  a_cap_store: assert property (p_cap_store) else $error("capture zero not stored");

  c_t2_ovf: cover property (ovf2);
  c_t2_match: cover property (match2 ##1 t2_flag);
  c_t0_split: cover property (t0_m3 && ovf0h);
endmodule

//--- logic/tmr_pkg.sv
// Register map, field layout and reset values for the timer block
package tmr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_TCTL  = 8'h88;
  localparam logic [7:0] IDX_TMODE = 8'h89;
  localparam logic [7:0] IDX_T0L   = 8'h8a;
  localparam logic [7:0] IDX_T1L   = 8'h8b;
  localparam logic [7:0] IDX_T0H   = 8'h8c;
  localparam logic [7:0] IDX_T1H   = 8'h8d;
  localparam logic [7:0] IDX_T2CTL = 8'hc8;
  localparam logic [7:0] IDX_TIMER2_MODE = 8'hc9;
  localparam logic [7:0] IDX_RCL   = 8'hca;
  localparam logic [7:0] IDX_RCH   = 8'hcb;
  localparam logic [7:0] IDX_T2L   = 8'hcc;
  localparam logic [7:0] IDX_T2H   = 8'hcd;
  localparam logic [7:0] IDX_CAP   = 8'he0;
  // Field positions in the timer control register
  localparam int TC_T1FLAG = 7;
  localparam int TC_T1RUN  = 6;
  localparam int TC_T0FLAG = 5;
  localparam int TC_T0RUN  = 4;
  // Field positions in the timer mode register (per nibble)
  localparam int TM_QUAL = 3;
  localparam int TM_CSEL = 2;
  // Field positions in timer two control and mode
  localparam int T2C_FLAG = 7;
  localparam int T2C_RUN  = 2;
  localparam int T2C_CSEL = 0;
  localparam int T2M_RELOAD_ENABLE = 7;
  localparam int T2M_DIV  = 4;
  localparam int T2M_CAPC = 3;
  localparam int T2M_CMPC = 2;
  localparam int T2M_TRIG = 0;
  // Reset values
  localparam logic [7:0] RST_REG   = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // Least timer two divide ratio is four
  localparam int T2_MIN_DIV = 4;
  // Bus state
  typedef enum logic [1:0] {TMR_BS_IDLE = 2'b00, TMR_BS_RDWAIT = 2'b01} tmr_bus_state_t;
endpackage

//--- sim/tmr_pins_model.sv
// Behavioural model of the timer block's count, gate and capture pins
`timescale 1ns/1ns
module tmr_pins_model (
  input  wire logic       hclk,
  output logic            count_input_zero,
  output logic            count_input_one,
  output logic            gate_pin_zero,
  output logic            gate_pin_one,
  output logic [2:0]      capture_pin
);
  // Idle levels: count pins high, gates open, capture lines low
  initial begin
    count_input_zero = 1'b1;
    count_input_one  = 1'b1;
    gate_pin_zero    = 1'b1;
    gate_pin_one     = 1'b1;
    capture_pin      = 3'h0;
  end

  // Holds a level long enough to pass the pin synchroniser
  task automatic hold();
    repeat (6) @(posedge hclk);
  endtask

  // Rising then falling edge on one capture channel
  task automatic cap_pulse(input int ch);
    @(posedge hclk);
    capture_pin[ch] <= 1'b1;
    hold();
    capture_pin[ch] <= 1'b0;
    hold();
  endtask

  // Falling edges on the timer zero count pin
  task automatic cnt_pulses(input int n);
    repeat (n) begin
      @(posedge hclk);
      count_input_zero <= 1'b0;
      hold();
      count_input_zero <= 1'b1;
      hold();
    end
  endtask

  // Level of the timer one gate pin
  task automatic gate_one(input logic g);
    @(posedge hclk);
    gate_pin_one <= g;
  endtask
endmodule

//--- sim/tb_timer_modes_and_t2_control.sv
// Self-checking testbench for the timer block over its register bus
`timescale 1ns/1ns
module tb_timer_modes_and_t2_control;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, capture_pin;
  logic        hreadyout, baud_tick, t0_ovf, t1_ovf, t2_flag;
  logic        cnt0, cnt1, gate0, gate1;
  logic [7:0]  v;
  logic [7:0]  n_baud = 8'h00;
  int          n_mismatch = 0;
  int          samples_checked = 0;

  always #5 hclk = ~hclk;

  tmr_timers #(.PRESCALE_01(2)) tmr_timers_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .count_input_zero(cnt0), .count_input_one(cnt1), .gate_pin_zero(gate0),
    .gate_pin_one(gate1), .capture_pin(capture_pin), .baud_tick(baud_tick),
    .timer_zero_overflow(t0_ovf), .timer_one_overflow(t1_ovf), .t2_flag(t2_flag));

  tmr_pins_model tmr_pins_model_inst (
    .hclk(hclk), .count_input_zero(cnt0), .count_input_one(cnt1),
    .gate_pin_zero(gate0), .gate_pin_one(gate1), .capture_pin(capture_pin));

  // Counts serial baud ticks
  always @(posedge hclk) begin
    if (baud_tick === 1'b1) begin
      n_baud <= n_baud + 8'h01;
    end
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // One single-word transfer: address phase, then data phase until ready
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {22'h0, idx, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
  endtask

  task automatic w(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] u;
    bus(1'b1, idx, d, u);
  endtask

  task automatic rc(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] u;
    bus(1'b0, idx, 8'h00, u);
    chk(e, u);
  endtask

  // Runs timer two with the given control value, then stops it keeping the flag
  task automatic t2_run(input logic [7:0] ctl, input int cyc);
    w(tmr_pkg::IDX_T2CTL, ctl);
    repeat (cyc) @(posedge hclk);
    w(tmr_pkg::IDX_T2CTL, {t2_flag, 7'h00});
  endtask

  // Watchdog cuts a hang short
  initial begin
    #300000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, read-write mode register, unmapped place
    rc(tmr_pkg::IDX_T2CTL, 8'h00);
    rc(tmr_pkg::IDX_TIMER2_MODE, 8'h00);
    w(tmr_pkg::IDX_TIMER2_MODE, 8'hff);
    rc(tmr_pkg::IDX_TIMER2_MODE, 8'hff);
    w(8'h40, 8'h5a);
    rc(8'h40, 8'h00);
    // Every prescale code: four periods give four or five counts, then hold
    for (int d = 0; d < 8; d++) begin
      w(tmr_pkg::IDX_T2L, 8'h00);
      w(tmr_pkg::IDX_T2H, 8'h00);
      w(tmr_pkg::IDX_TIMER2_MODE, 8'(d << 4));
      t2_run(8'h04, 4 * (4 << d));
      bus(1'b0, tmr_pkg::IDX_T2L, 8'h00, v);
      chk(8'h01, {7'h0, v >= 8'h04 && v <= 8'h05});
      repeat (30) @(posedge hclk);
      rc(tmr_pkg::IDX_T2L, v);
    end
    // Wrap from all ones: flag set, high byte follows the low byte
    w(tmr_pkg::IDX_T2CTL, 8'h00);
    w(tmr_pkg::IDX_TIMER2_MODE, 8'h00);
    w(tmr_pkg::IDX_T2H, 8'hff);
    w(tmr_pkg::IDX_T2L, 8'hfe);
    t2_run(8'h04, 12);
    chk(8'h01, {7'h0, t2_flag});
    rc(tmr_pkg::IDX_T2H, 8'h00);
    rc(tmr_pkg::IDX_T2CTL, 8'h80);
    w(tmr_pkg::IDX_T2CTL, 8'h00);
    @(posedge hclk);
    chk(8'h00, {7'h0, t2_flag});
    // Reload on overflow
    w(tmr_pkg::IDX_RCL, 8'h34);
    w(tmr_pkg::IDX_RCH, 8'h12);
    w(tmr_pkg::IDX_TIMER2_MODE, 8'h80);
    w(tmr_pkg::IDX_T2H, 8'hff);
    w(tmr_pkg::IDX_T2L, 8'hfe);
    t2_run(8'h04, 12);
    rc(tmr_pkg::IDX_T2H, 8'h12);
    // Compare mode with auto-clear at a match of five
    w(tmr_pkg::IDX_T2CTL, 8'h00);
    w(tmr_pkg::IDX_RCL, 8'h05);
    w(tmr_pkg::IDX_RCH, 8'h00);
    w(tmr_pkg::IDX_TIMER2_MODE, 8'h04);
    w(tmr_pkg::IDX_T2L, 8'h00);
    w(tmr_pkg::IDX_T2H, 8'h00);
    t2_run(8'h05, 30);
    chk(8'h01, {7'h0, t2_flag});
    bus(1'b0, tmr_pkg::IDX_T2L, 8'h00, v);
    chk(8'h01, {7'h0, v < 8'h05});
    // Capture on each channel with reload triggered by that channel
    w(tmr_pkg::IDX_T2CTL, 8'h00);
    w(tmr_pkg::IDX_RCL, 8'h77);
    w(tmr_pkg::IDX_RCH, 8'h5a);
    for (int ch = 0; ch < 3; ch++) begin
      w(tmr_pkg::IDX_TIMER2_MODE, 8'h80 | 8'(ch + 1));
      w(tmr_pkg::IDX_T2L, 8'h30 + 8'(ch));
      w(tmr_pkg::IDX_T2H, 8'h12);
      tmr_pins_model_inst.cap_pulse(ch);
      rc(tmr_pkg::IDX_CAP + 8'(2 * ch), 8'h30 + 8'(ch));
      rc(tmr_pkg::IDX_CAP + 8'(2 * ch + 1), 8'h12);
      rc(tmr_pkg::IDX_T2L, 8'h77);
      rc(tmr_pkg::IDX_T2H, 8'h5a);
    end
    // Capture auto-clear without reload
    w(tmr_pkg::IDX_TIMER2_MODE, 8'h08);
    w(tmr_pkg::IDX_T2L, 8'h44);
    tmr_pins_model_inst.cap_pulse(1);
    rc(tmr_pkg::IDX_CAP + 8'h02, 8'h44);
    rc(tmr_pkg::IDX_T2L, 8'h00);
    // Timer zero mode 1 wrap, no baud ticks from timer zero
    w(tmr_pkg::IDX_TMODE, 8'h01);
    w(tmr_pkg::IDX_T0H, 8'hff);
    w(tmr_pkg::IDX_T0L, 8'hfe);
    w(tmr_pkg::IDX_TCTL, 8'h10);
    repeat (12) @(posedge hclk);
    w(tmr_pkg::IDX_TCTL, {2'b00, t0_ovf, 5'h00});
    chk(8'h01, {7'h0, t0_ovf});
    rc(tmr_pkg::IDX_T0H, 8'h00);
    chk(8'h00, n_baud);
    // Timer one mode 2 reload drives baud ticks
    w(tmr_pkg::IDX_TMODE, 8'h20);
    w(tmr_pkg::IDX_T1H, 8'hc0);
    w(tmr_pkg::IDX_T1L, 8'hfe);
    w(tmr_pkg::IDX_TCTL, 8'h40);
    repeat (20) @(posedge hclk);
    w(tmr_pkg::IDX_TCTL, {t1_ovf, 7'h00});
    chk(8'h01, {7'h0, t1_ovf});
    rc(tmr_pkg::IDX_T1H, 8'hc0);
    bus(1'b0, tmr_pkg::IDX_T1L, 8'h00, v);
    chk(8'h01, {7'h0, v >= 8'hc0});
    chk(8'h01, {7'h0, n_baud != 8'h00});
    // Qualified gate: closed gate stops counting, open gate counts
    w(tmr_pkg::IDX_TMODE, 8'ha0);
    w(tmr_pkg::IDX_T1L, 8'hc5);
    tmr_pins_model_inst.gate_one(1'b0);
    repeat (4) @(posedge hclk); // Closed gate passes the pin synchroniser first
    w(tmr_pkg::IDX_TCTL, 8'h40);
    repeat (20) @(posedge hclk);
    rc(tmr_pkg::IDX_T1L, 8'hc5);
    tmr_pins_model_inst.gate_one(1'b1);
    repeat (20) @(posedge hclk);
    bus(1'b0, tmr_pkg::IDX_T1L, 8'h00, v);
    chk(8'h01, {7'h0, v != 8'hc5});
    // Timer one in mode 3 holds its count
    w(tmr_pkg::IDX_TCTL, 8'h00);
    w(tmr_pkg::IDX_TMODE, 8'h31);
    w(tmr_pkg::IDX_T1L, 8'h10);
    w(tmr_pkg::IDX_TCTL, 8'h40);
    repeat (20) @(posedge hclk);
    rc(tmr_pkg::IDX_T1L, 8'h10);
    // Timer zero mode 3: high byte on timer one controls, timer one leaves mode 3
    w(tmr_pkg::IDX_T0H, 8'hfe);
    w(tmr_pkg::IDX_T0L, 8'h20);
    w(tmr_pkg::IDX_TMODE, 8'h13);
    repeat (20) @(posedge hclk);
    chk(8'h01, {7'h0, t1_ovf});
    rc(tmr_pkg::IDX_T0L, 8'h20);
    bus(1'b0, tmr_pkg::IDX_T1L, 8'h00, v);
    chk(8'h01, {7'h0, v != 8'h10});
    // Timer zero low byte counts pin edges, timer one stopped by mode 3
    w(tmr_pkg::IDX_TMODE, 8'h37);
    w(tmr_pkg::IDX_TCTL, 8'h10);
    w(tmr_pkg::IDX_T0L, 8'h00);
    tmr_pins_model_inst.cnt_pulses(3);
    rc(tmr_pkg::IDX_T0L, 8'h03);
    end_sim();
  end
endmodule
